// >>> bench/sio_io_conditioning_bench.sv
`timescale 1ns/1ps
`include "sio_params.svh"

module sio_io_conditioning_bench
    import sio_pkg::*;
;
    logic clk, sys_rst, cfg_load, cfg_programmed, warning_any, cfg_latched, smbus_wr;
    sio_in_cfg_t [4:0] load_in_cfg;
    sio_out_cfg_t [9:0] load_out_cfg;
    logic [4:0] dual_function_input, cmp_raw, dual_pull_down_en, fault_sfd_valid, fault_sfd;
    logic [4:0] warn_status, digital_to_engine, drv_en, drv_val;
    logic [9:0] engine_out, smbus_wr_data, smbus_level, smb_m;
    sio_pin_t [9:0] programmable_driver_output;
    int fail_count = 0;
    int comparisons = 0;
    logic [31:0] seed = 32'h1b6c;
    int cnt, first, hi, tr, wcnt;
    int t_idx[7] = '{0, 0, 1, 1, 1, 2, 3};
    bit t_cmp[7] = '{1, 1, 1, 0, 0, 0, 0};
    int t_w[7] = '{10, 50, 50, 10, 50, 50, 50};
    int t_exp[7] = '{0, 50, 50, 0, 50, 60, 0};

    sio_io_conditioning sio_io_conditioning_i (.clk(clk), .sys_rst(sys_rst),
        .cfg_load(cfg_load), .cfg_programmed(cfg_programmed), .load_in_cfg(load_in_cfg),
        .load_out_cfg(load_out_cfg), .dual_function_input(dual_function_input),
        .cmp_raw(cmp_raw), .dual_pull_down_en(dual_pull_down_en),
        .fault_sfd_valid(fault_sfd_valid), .fault_sfd(fault_sfd), .warn_status(warn_status),
        .warning_any(warning_any), .digital_to_engine(digital_to_engine),
        .cfg_latched(cfg_latched), .engine_out(engine_out), .smbus_wr(smbus_wr),
        .smbus_wr_data(smbus_wr_data), .smbus_level(smbus_level),
        .programmable_driver_output(programmable_driver_output));
    sio_partner sio_partner_i (.clk(clk), .drv_en(drv_en), .drv_val(drv_val),
        .pd_en(dual_pull_down_en), .pin(dual_function_input));

    // ----------------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return s[0] ? ((s >> 1) ^ 32'h8020_0003) : (s >> 1);
    endfunction : lfsr
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask : tick
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            $display("Error %s expected %0h seen %0h", name, exp, got);
            fail_count++;
        end
    endtask : check
    task automatic wrap_up();
        if (fail_count == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : wrap_up
    // Output i uses drive mode (i+7)%8 and source i%3; clock-sourced ones are skipped
    task automatic check_pins();
        int m;
        logic d;
        for (int i = 0; i < 10; i++) begin
            m = (i + 7) % 8;
            d = (i % 3 == 0) ? engine_out[i] : smb_m[i];
            if (i % 3 == 2) continue;
            if (m == 0 || (m == 7 && i >= 6)) begin
                check("weak_pull_down", 1, programmable_driver_output[i].weak_pull_down);
            end else if (m == 7) begin
                check("charge_pump", d, programmable_driver_output[i].charge_pump);
            end else if (m == 6) begin
                // Strong pull-down holds the pin low whatever the data source says
                check("drive_low", 1, programmable_driver_output[i].drive_low);
            end else begin
                check("drive_low", !d, programmable_driver_output[i].drive_low);
                if (m == 3 || m == 5) begin
                    check("drive_high", d, programmable_driver_output[i].drive_high);
                end
            end
        end
    endtask : check_pins
    task automatic run(input int idx, input bit use_cmp, input int width,
        output int n, output int f);
        n = 0;
        f = -1;
        wcnt = 0;
        for (int t = 0; t < 150; t++) begin
            if (use_cmp) cmp_raw[idx] = (t < width);
            else drv_val[idx] = (t < width);
            tick(1);
            if (warning_any === 1'b1) wcnt++;
            if ((use_cmp ? (fault_sfd[idx] | warn_status[idx]) : digital_to_engine[idx])
                === 1'b1) begin
                if (f < 0) f = t;
                n++;
            end
        end
    endtask : run

    // ----------------------------------------------------------------------
    // Stimulus
    // ----------------------------------------------------------------------
    initial begin
        clk = 0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        #(25 * 20000);
        fail_count++;
        wrap_up();
    end
    initial begin
        sys_rst = 1;
        cfg_load = 0;
        cfg_programmed = 0;
        cmp_raw = 5'h00;
        engine_out = 10'h000;
        smbus_wr = 0;
        smbus_wr_data = 10'h000;
        drv_en = 5'h1f;
        drv_val = 5'h00;
        smb_m = 10'h000;
        load_in_cfg[0] = '{1'b0, 1'b0, 1'b1, 13'h0014, 13'h0000};
        load_in_cfg[1] = '{1'b1, 1'b0, 1'b1, 13'h0014, 13'h0000};
        load_in_cfg[2] = '{1'b1, 1'b1, 1'b0, 13'h0014, 13'h001e};
        load_in_cfg[3] = '{1'b1, 1'b1, 1'b0, 13'h0014, 13'h0000};
        load_in_cfg[4] = '{1'b1, 1'b0, 1'b0, 13'h0000, 13'h0000};
        for (int i = 0; i < 10; i++) begin
            load_out_cfg[i] = '{sio_drive_t'((i + 7) % 8), sio_src_t'(i % 3)};
        end
        tick(10);
        sys_rst = 0;
        check("smbus_level", 0, smbus_level);
        cfg_load = 1;
        tick(1);
        cfg_load = 0;
        tick(1);
        check("cfg_latched", 0, cfg_latched);
        cfg_programmed = 1;
        cfg_load = 1;
        tick(1);
        cfg_load = 0;
        load_out_cfg = '0;
        tick(2);
        check("cfg_latched", 1, cfg_latched);
        check("fault_sfd_valid", 5'h01, fault_sfd_valid);
        check("dual_pull_down_en", 5'h02, dual_pull_down_en);
        cfg_load = 1;
        tick(1);
        cfg_load = 0;
        for (int k = 0; k < 16; k++) begin
            seed = lfsr(seed);
            engine_out = seed[9:0];
            smbus_wr = seed[10];
            smbus_wr_data = seed[20:11];
            if (seed[10]) smb_m = seed[20:11];
            tick(1);
            smbus_wr = 0;
            tick(2);
            check("smbus_level", smb_m, smbus_level);
            check_pins();
        end
        hi = 0;
        tr = 0;
        for (int t = 0; t < 400; t++) begin
            tick(1);
            if (programmable_driver_output[2].drive_low === 1'b0) hi++;
            if (t > 0 && programmable_driver_output[2].drive_low != first[0]) tr++;
            first = programmable_driver_output[2].drive_low;
        end
        check("clock_high_cycles", 200, hi);
        check("clock_edges", 2, tr);
        for (int j = 0; j < 7; j++) begin
            run(t_idx[j], t_cmp[j], t_w[j], cnt, first);
            check("pulse_count", t_exp[j], cnt);
            if (t_exp[j] == 50) check("delay_ok", 1, first >= 20 && first <= 26);
            if (t_cmp[j]) check("warning_count", t_idx[j] != 0 ? t_exp[j] : 0, wcnt);
        end
        // Start high so that only a working pull-down can bring the released pin low
        drv_val[1] = 1;
        tick(30);
        check("driven_level", 1, digital_to_engine[1]);
        drv_en[1] = 0;
        tick(40);
        check("floating_level", 0, digital_to_engine[1]);
        sys_rst = 1;
        tick(2);
        sys_rst = 0;
        check("cfg_latched", 0, cfg_latched);
        check("smbus_level", 0, smbus_level);
        wrap_up();
    end
endmodule : sio_io_conditioning_bench

// >>> bench/sio_io_conditioning_chk.sv
`timescale 1ns/1ps
`include "sio_params.svh"

module sio_io_conditioning_chk
    import sio_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic cfg_load,
    input wire logic cfg_programmed,
    input wire logic [`SIO_NUM_IN-1:0] dual_pull_down_en,
    input wire logic [`SIO_NUM_IN-1:0] fault_sfd_valid,
    input wire logic [`SIO_NUM_IN-1:0] fault_sfd,
    input wire logic [`SIO_NUM_IN-1:0] warn_status,
    input wire logic warning_any,
    input wire logic cfg_latched,
    input wire logic smbus_wr,
    input wire logic [`SIO_NUM_OUT-1:0] smbus_wr_data,
    input wire logic [`SIO_NUM_OUT-1:0] smbus_level,
    input wire sio_pin_t [`SIO_NUM_OUT-1:0] programmable_driver_output
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // ----------------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------------
    property p_reset_pins;
        disable iff (1'b0) sys_rst |=> programmable_driver_output == {10{7'h01}};
    endproperty
    a_reset_pins: assert property (p_reset_pins) else $error("pins not weak low after reset");
    property p_unlatched;
        !cfg_latched |-> programmable_driver_output == {10{7'h01}};
    endproperty
    a_unlatched: assert property (p_unlatched) else $error("pins left weak low early");
    property p_latch;
        cfg_load && cfg_programmed && !cfg_latched |=> cfg_latched;
    endproperty
    a_latch: assert property (p_latch) else $error("config not latched");
    property p_unprog;
        !cfg_programmed && !cfg_latched |=> !cfg_latched;
    endproperty
    a_unprog: assert property (p_unprog) else $error("unprogrammed part latched");
    property p_latch_stands;
        cfg_latched |=> cfg_latched;
    endproperty
    a_latch_stands: assert property (p_latch_stands) else $error("latch dropped");
    property p_warn_or;
        warning_any == (|warn_status);
    endproperty
    a_warn_or: assert property (p_warn_or) else $error("warning not an OR");
    property p_mode_excl;
        (warn_status & fault_sfd_valid) == 5'h00;
    endproperty
    a_mode_excl: assert property (p_mode_excl) else $error("warning in analog mode");
    property p_fault_valid;
        (fault_sfd & ~fault_sfd_valid) == 5'h00;
    endproperty
    a_fault_valid: assert property (p_fault_valid) else $error("fault in digital mode");
    property p_pull_down;
        (dual_pull_down_en & fault_sfd_valid) == 5'h00;
    endproperty
    a_pull_down: assert property (p_pull_down) else $error("pull-down in analog mode");
    property p_smb_store;
        smbus_wr |=> smbus_level == $past(smbus_wr_data);
    endproperty
    a_smb_store: assert property (p_smb_store) else $error("smbus level not stored");
    property p_smb_hold;
        !smbus_wr |=> $stable(smbus_level);
    endproperty
    a_smb_hold: assert property (p_smb_hold) else $error("smbus level moved");
endmodule : sio_io_conditioning_chk

bind sio_io_conditioning sio_io_conditioning_chk sio_io_conditioning_chk_i (.clk(clk),
    .sys_rst(sys_rst), .cfg_load(cfg_load), .cfg_programmed(cfg_programmed),
    .dual_pull_down_en(dual_pull_down_en), .fault_sfd_valid(fault_sfd_valid),
    .fault_sfd(fault_sfd), .warn_status(warn_status), .warning_any(warning_any),
    .cfg_latched(cfg_latched), .smbus_wr(smbus_wr), .smbus_wr_data(smbus_wr_data),
    .smbus_level(smbus_level), .programmable_driver_output(programmable_driver_output));

// >>> bench/sio_partner.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// External logic on the dual-function pins
// ----------------------------------------------------------------------
module sio_partner (
    input wire logic clk,
    input wire logic [4:0] drv_en,
    input wire logic [4:0] drv_val,
    input wire logic [4:0] pd_en,
    output logic [4:0] pin
);
    logic [4:0] last = 5'h00;
    // A released pin with no pull-down wanders, shown as a toggle
    always @(posedge clk) begin
        for (int i = 0; i < 5; i++) begin
            if (drv_en[i]) begin
                last[i] <= drv_val[i];
            end else if (pd_en[i]) begin
                last[i] <= 1'b0;
            end else begin
                last[i] <= ~last[i];
            end
        end
    end
    assign pin = last;
endmodule : sio_partner

// >>> design/sio_clkdiv.sv
`timescale 1ns/1ps
`include "sio_params.svh"

module sio_clkdiv
    import sio_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    output logic oclk
);

    logic [7:0] cnt;

    // Toggle every half period for an even duty cycle
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cnt <= '0;
            oclk <= 1'b0;
        end else if (cnt == 8'(`SIO_OCLK_HALF - 1)) begin
            cnt <= '0;
            oclk <= ~oclk;
        end else begin
            cnt <= cnt + 1'b1;
        end
    end

endmodule : sio_clkdiv

// >>> design/sio_filter.sv
`timescale 1ns/1ps
`include "sio_params.svh"

module sio_filter
    import sio_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic raw,
    input wire logic [`SIO_CNT_W-1:0] timeout,
    output logic filt
);

    logic [`SIO_CNT_W-1:0] count;

    // Output follows the raw level only after it has stood for timeout cycles
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            count <= '0;
            filt <= 1'b0;
        end else if (raw == filt) begin
            count <= '0;
        end else if (count >= timeout) begin
            filt <= raw;
            count <= '0;
        end else begin
            count <= count + 1'b1;
        end
    end

endmodule : sio_filter

// >>> design/sio_io_conditioning.sv
`timescale 1ns/1ps
`include "sio_params.svh"

module sio_io_conditioning
    import sio_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    // Configuration load, pulsed once the supply is good and EEPROM read
    input wire logic cfg_load,
    input wire logic cfg_programmed,
    input wire sio_in_cfg_t [`SIO_NUM_IN-1:0] load_in_cfg,
    input wire sio_out_cfg_t [`SIO_NUM_OUT-1:0] load_out_cfg,
    // Dual-function inputs
    input wire logic [`SIO_NUM_IN-1:0] dual_function_input,
    input wire logic [`SIO_NUM_IN-1:0] cmp_raw,
    output logic [`SIO_NUM_IN-1:0] dual_pull_down_en,
    // Detector routing
    output logic [`SIO_NUM_IN-1:0] fault_sfd_valid,
    output logic [`SIO_NUM_IN-1:0] fault_sfd,
    output logic [`SIO_NUM_IN-1:0] warn_status,
    output logic warning_any,
    output logic [`SIO_NUM_IN-1:0] digital_to_engine,
    output logic cfg_latched,
    // Output data
    input wire logic [`SIO_NUM_OUT-1:0] engine_out,
    input wire logic smbus_wr,
    input wire logic [`SIO_NUM_OUT-1:0] smbus_wr_data,
    output logic [`SIO_NUM_OUT-1:0] smbus_level,
    output sio_pin_t [`SIO_NUM_OUT-1:0] programmable_driver_output
);

    // ------------------------------------------------------------------
    // Latched configuration
    // ------------------------------------------------------------------
    sio_in_cfg_t [`SIO_NUM_IN-1:0] in_cfg;
    sio_out_cfg_t [`SIO_NUM_OUT-1:0] out_cfg;

    // Unprogrammed parts never latch, so their all-zero setup holds
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cfg_latched <= 1'b0;
            in_cfg <= '0;
            out_cfg <= '0;
        end else if (cfg_load && cfg_programmed && !cfg_latched) begin
            cfg_latched <= 1'b1;
            in_cfg <= load_in_cfg;
            out_cfg <= load_out_cfg;
        end
    end

    // ------------------------------------------------------------------
    // Dual-function inputs
    // ------------------------------------------------------------------
    logic [`SIO_NUM_IN-1:0] filt_dig;
    logic [`SIO_NUM_IN-1:0] filt_cmp;
    logic [`SIO_NUM_IN-1:0] filt_dig_d;
    logic [`SIO_CNT_W-1:0] pulse_cnt [`SIO_NUM_IN];
    logic [`SIO_NUM_IN-1:0] pulse;

    genvar gi;
    generate
        for (gi = 0; gi < `SIO_NUM_IN; gi++) begin : g_in
            // Same filter as the comparator path
            sio_filter u_dig_filt (
                .clk(clk),
                .sys_rst(sys_rst),
                .raw(dual_function_input[gi]),
                .timeout(in_cfg[gi].filter_cyc),
                .filt(filt_dig[gi])
            );
            sio_filter u_cmp_filt (
                .clk(clk),
                .sys_rst(sys_rst),
                .raw(cmp_raw[gi]),
                .timeout(in_cfg[gi].filter_cyc),
                .filt(filt_cmp[gi])
            );

            // Pulse width is capped so a bad load cannot exceed the limit
            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    pulse_cnt[gi] <= '0;
                    pulse[gi] <= 1'b0;
                end else if (filt_dig[gi] != filt_dig_d[gi]) begin
                    pulse_cnt[gi] <= (in_cfg[gi].pulse_cyc > `SIO_CNT_W'(`SIO_MAX_CYC)) ?
                        `SIO_CNT_W'(`SIO_MAX_CYC) : in_cfg[gi].pulse_cyc;
                    pulse[gi] <= (in_cfg[gi].pulse_cyc != '0);
                end else if (pulse_cnt[gi] > `SIO_CNT_W'(1)) begin
                    pulse_cnt[gi] <= pulse_cnt[gi] - 1'b1;
                end else begin
                    pulse_cnt[gi] <= '0;
                    pulse[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            filt_dig_d <= '0;
        end else begin
            filt_dig_d <= filt_dig;
        end
    end

    // Comparator always runs in the low range; only its meaning changes
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            fault_sfd_valid <= '0;
            fault_sfd <= '0;
            warn_status <= '0;
            digital_to_engine <= '0;
            dual_pull_down_en <= '0;
        end else begin
            for (int i = 0; i < `SIO_NUM_IN; i++) begin
                fault_sfd_valid[i] <= !in_cfg[i].digital;
                fault_sfd[i] <= !in_cfg[i].digital && filt_cmp[i];
                // Index i maps to positive input i, the last to the high input
                warn_status[i] <= in_cfg[i].digital && filt_cmp[i];
                if (!in_cfg[i].digital) begin
                    digital_to_engine[i] <= 1'b0;
                end else if (in_cfg[i].edge_mode) begin
                    digital_to_engine[i] <= pulse[i];
                end else begin
                    digital_to_engine[i] <= filt_dig[i];
                end
                dual_pull_down_en[i] <= in_cfg[i].digital && in_cfg[i].pull_down;
            end
        end
    end

    assign warning_any = |warn_status;

    // ------------------------------------------------------------------
    // Internal output clock
    // ------------------------------------------------------------------
    logic oclk;

    sio_clkdiv u_clkdiv (
        .clk(clk),
        .sys_rst(sys_rst),
        .oclk(oclk)
    );

    // ------------------------------------------------------------------
    // SMBus-held levels
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            smbus_level <= {`SIO_NUM_OUT{`SIO_SMB_RESET}};
        end else if (smbus_wr) begin
            smbus_level <= smbus_wr_data;
        end
    end

    // ------------------------------------------------------------------
    // Output drivers
    // ------------------------------------------------------------------
    logic [`SIO_NUM_OUT-1:0] out_data;

    always_comb begin
        for (int j = 0; j < `SIO_NUM_OUT; j++) begin
            case (out_cfg[j].src)
                SIO_SRC_ENGINE: out_data[j] = engine_out[j];
                SIO_SRC_SMBUS: out_data[j] = smbus_level[j];
                SIO_SRC_CLOCK: out_data[j] = oclk;
                default: out_data[j] = 1'b0;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            for (int j = 0; j < `SIO_NUM_OUT; j++) begin
                programmable_driver_output[j] <= '0;
                programmable_driver_output[j].weak_pull_down <= 1'b1;
            end
        end else begin
            for (int j = 0; j < `SIO_NUM_OUT; j++) begin
                programmable_driver_output[j] <= '0;
                if (!cfg_latched) begin
                    programmable_driver_output[j].weak_pull_down <= 1'b1;
                end else begin
                    case (out_cfg[j].drive)
                        SIO_DRV_WEAK_PD: begin
                            programmable_driver_output[j].weak_pull_down <= 1'b1;
                        end
                        SIO_DRV_OPEN_DRAIN: begin
                            programmable_driver_output[j].drive_low <= !out_data[j];
                        end
                        SIO_DRV_OD_WEAK_PU_VDD: begin
                            programmable_driver_output[j].drive_low <= !out_data[j];
                            programmable_driver_output[j].pull_up_weak <= out_data[j];
                        end
                        SIO_DRV_OD_STRONG_PU_VDD: begin
                            programmable_driver_output[j].drive_low <= !out_data[j];
                            programmable_driver_output[j].pull_up_strong <= out_data[j];
                            programmable_driver_output[j].drive_high <= out_data[j];
                        end
                        SIO_DRV_OD_WEAK_PU_VP: begin
                            programmable_driver_output[j].drive_low <= !out_data[j];
                            programmable_driver_output[j].pull_up_weak <= out_data[j];
                            programmable_driver_output[j].pull_to_vp <= 1'b1;
                        end
                        SIO_DRV_OD_STRONG_PU_VP: begin
                            programmable_driver_output[j].drive_low <= !out_data[j];
                            programmable_driver_output[j].pull_up_strong <= out_data[j];
                            programmable_driver_output[j].drive_high <= out_data[j];
                            programmable_driver_output[j].pull_to_vp <= 1'b1;
                        end
                        SIO_DRV_STRONG_PD: begin
                            programmable_driver_output[j].drive_low <= 1'b1;
                        end
                        SIO_DRV_CHARGE_PUMP: begin
                            // High drive exists only on the first six pins
                            if (j < `SIO_NUM_CP) begin
                                programmable_driver_output[j].charge_pump <= out_data[j];
                                programmable_driver_output[j].drive_low <= !out_data[j];
                            end else begin
                                programmable_driver_output[j].weak_pull_down <= 1'b1;
                            end
                        end
                        default: begin
                            programmable_driver_output[j].weak_pull_down <= 1'b1;
                        end
                    endcase
                end
            end
        end
    end

endmodule : sio_io_conditioning

// >>> design/sio_params.svh
`ifndef SIO_PARAMS_SVH
`define SIO_PARAMS_SVH

// ----------------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------------
`define SIO_NUM_IN 5
`define SIO_NUM_OUT 10
`define SIO_NUM_CP 6

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define SIO_CLK_HZ 40000000
`define SIO_MAX_TIME_US 100
// Longest pulse time, in cycles (100 us at 40 MHz); filter times are not capped by it
`define SIO_MAX_CYC ((`SIO_MAX_TIME_US * (`SIO_CLK_HZ / 1000000)))
`define SIO_OCLK_HZ 100000
// Half period of the output clock, in cycles
`define SIO_OCLK_HALF (`SIO_CLK_HZ / (2 * `SIO_OCLK_HZ))
`define SIO_CNT_W 13

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define SIO_CFG_RESET 8'h00
`define SIO_SMB_RESET 1'b0

`endif

// >>> design/sio_pkg.sv
package sio_pkg;

    // Drive mode of one output pin; zero is weak pull-down (unprogrammed)
    typedef enum logic [2:0] {
        SIO_DRV_WEAK_PD,
        SIO_DRV_OPEN_DRAIN,
        SIO_DRV_OD_WEAK_PU_VDD,
        SIO_DRV_OD_STRONG_PU_VDD,
        SIO_DRV_OD_WEAK_PU_VP,
        SIO_DRV_OD_STRONG_PU_VP,
        SIO_DRV_STRONG_PD,
        SIO_DRV_CHARGE_PUMP
    } sio_drive_t;

    typedef enum logic [1:0] {
        SIO_SRC_ENGINE,
        SIO_SRC_SMBUS,
        SIO_SRC_CLOCK,
        SIO_SRC_NONE
    } sio_src_t;

    // Configuration of one output
    typedef struct packed {
        sio_drive_t drive;
        sio_src_t src;
    } sio_out_cfg_t;

    // Configuration of one dual-function input
    typedef struct packed {
        logic digital;
        logic edge_mode;
        logic pull_down;
        logic [12:0] filter_cyc;
        logic [12:0] pulse_cyc;
    } sio_in_cfg_t;

    // Pin controls of one output
    typedef struct packed {
        logic drive_low;
        logic drive_high;
        logic pull_up_weak;
        logic pull_up_strong;
        logic pull_to_vp;
        logic charge_pump;
        logic weak_pull_down;
    } sio_pin_t;

endpackage : sio_pkg
